// File: rtl/pq_irq_pkg.sv
package pq_irq_pkg;

	// ------------------------------------------------------------
	// register map: printed offsets are indices, byte address = 4x
	// ------------------------------------------------------------
	localparam int ADDR_W = 18;
	localparam logic [15:0] ENABLE_IDX = 16'he50a;
	localparam logic [15:0] STATUS_IDX = 16'he502;
	localparam logic [15:0] PHSRC_IDX = 16'he600;

	// ------------------------------------------------------------
	// reset values and implemented-bit masks
	// ------------------------------------------------------------
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] PHSRC_RESET = 32'h0000_0000;
	localparam logic [31:0] ENABLE_WR_MASK = 32'h018f_fffd;
	localparam logic [31:0] GATE_MASK = 32'h018f_7ffd;
	localparam logic [31:0] STATUS_MASK = 32'h018f_fffd;
	localparam logic [31:0] PHSRC_MASK = 32'h0000_7e38;

	// ------------------------------------------------------------
	// bit positions of enable and status fields
	// ------------------------------------------------------------
	localparam int B_NOLOAD_PQ = 0;
	localparam int B_NOLOAD_APP = 2;
	localparam int B_VOLT_TIMEOUT = 3;
	localparam int B_CURR_TIMEOUT = 6;
	localparam int B_VOLT_CROSS = 9;
	localparam int B_CURR_CROSS = 12;
	localparam int B_RESET_DONE = 15;
	localparam int B_DIP = 16;
	localparam int B_HIGH_CURR = 17;
	localparam int B_HIGH_VOLT = 18;
	localparam int B_PHASE_ORDER = 19;
	localparam int B_PEAK_CURR = 23;
	localparam int B_PEAK_VOLT = 24;

	// ------------------------------------------------------------
	// phase source field positions
	// ------------------------------------------------------------
	localparam int P_HIGH_CURR = 3;
	localparam int P_HIGH_VOLT = 9;
	localparam int P_DIP = 12;

	// ------------------------------------------------------------
	// bus phase tracking
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACCESS = 2'b10
	} apb_state_e;

endpackage : pq_irq_pkg

// File: rtl/sticky_flags.sv
`timescale 1ns/100ps
module sticky_flags #(
	parameter int W = 32,
	parameter logic [W-1:0] MASK = '1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// flag control
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] flags
);

	typedef struct packed {
		logic [W-1:0] flags;
	} flag_regs_s;

	flag_regs_s r;
	flag_regs_s next_r;

	if (W < 1)
	begin : g_bad_width
		$error("sticky_flags needs W of at least 1");
	end

	// a set arriving with its own clear must not be lost
	always_comb
	begin
		next_r = r;
		next_r.flags = ((r.flags & ~clr) | set) & MASK;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '{flags: RESET_VAL};
		else
			r <= next_r;
	end

	assign flags = r.flags;

endmodule : sticky_flags

// File: rtl/power_quality_irq_mask.sv
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module power_quality_irq_mask
	import pq_irq_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pq_irq_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event detectors, one-cycle pulses in status bit layout
	input wire logic [31:0] event_pulse,
	input wire logic [2:0] high_current_phase_flags,
	input wire logic [2:0] high_voltage_phase_flags,
	input wire logic [2:0] dip_phase_flags,
	// interrupt request, active low
	output logic irq_n
);

	import pq_irq_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		apb_state_e state;
		logic [31:0] rdata;
		logic err;
		logic [31:0] enable;
		logic booted;
	} regs_s;

	regs_s r;
	regs_s next_r;

	logic [31:0] status;
	logic [31:0] status_set;
	logic [31:0] status_clr;
	logic [31:0] phase_source_status;
	logic [31:0] phsrc_set;
	logic [31:0] phsrc_clr;
	logic [31:0] pend;
	logic [31:0] rd_mux;
	logic setup;
	logic commit;
	logic aligned;
	logic sel_enable;
	logic sel_status;
	logic sel_phsrc;
	logic hit;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	assign aligned = (paddr[1:0] == 2'h0);
	assign sel_enable = aligned && (paddr[ADDR_W-1:2] == ENABLE_IDX);
	assign sel_status = aligned && (paddr[ADDR_W-1:2] == STATUS_IDX);
	assign sel_phsrc = aligned && (paddr[ADDR_W-1:2] == PHSRC_IDX);
	assign hit = sel_enable || sel_status || sel_phsrc;

	assign setup = psel && !penable;
	assign pready = (r.state == ST_ACCESS);
	// writes land only on the completing edge of the access phase
	assign commit = psel && penable && pready;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (sel_enable)
			rd_mux = r.enable;
		else if (sel_status)
			rd_mux = status;
		else if (sel_phsrc)
			rd_mux = phase_source_status;
	end

	// ------------------------------------------------------------
	// event status, write one to clear
	// ------------------------------------------------------------
	always_comb
	begin
		status_set = event_pulse & STATUS_MASK;
		status_set[B_RESET_DONE] = !r.booted;
		status_clr = 32'h0000_0000;
		if (commit && pwrite && sel_status)
			status_clr = pwdata & STATUS_MASK;
	end

	sticky_flags #(
		.W(32),
		.MASK(STATUS_MASK),
		.RESET_VAL(STATUS_RESET)
	) u_status (
		.pclk(pclk),
		.presetn(presetn),
		.set(status_set),
		.clr(status_clr),
		.flags(status)
	);

	// ------------------------------------------------------------
	// phase source flags
	// ------------------------------------------------------------
	// cleared together with their event bit so software sees a matched pair
	always_comb
	begin
		phsrc_set = 32'h0000_0000;
		phsrc_clr = 32'h0000_0000;
		if (event_pulse[B_HIGH_CURR])
			phsrc_set[P_HIGH_CURR +: 3] = high_current_phase_flags;
		if (event_pulse[B_HIGH_VOLT])
			phsrc_set[P_HIGH_VOLT +: 3] = high_voltage_phase_flags;
		if (event_pulse[B_DIP])
			phsrc_set[P_DIP +: 3] = dip_phase_flags;
		phsrc_clr[P_HIGH_CURR +: 3] = {3{status_clr[B_HIGH_CURR]}};
		phsrc_clr[P_HIGH_VOLT +: 3] = {3{status_clr[B_HIGH_VOLT]}};
		phsrc_clr[P_DIP +: 3] = {3{status_clr[B_DIP]}};
	end

	sticky_flags #(
		.W(32),
		.MASK(PHSRC_MASK),
		.RESET_VAL(PHSRC_RESET)
	) u_phsrc (
		.pclk(pclk),
		.presetn(presetn),
		.set(phsrc_set),
		.clr(phsrc_clr),
		.flags(phase_source_status)
	);

	// ------------------------------------------------------------
	// interrupt gating
	// ------------------------------------------------------------
	always_comb
	begin
		pend = 32'h0000_0000;
		pend[B_NOLOAD_PQ] = status[B_NOLOAD_PQ] & r.enable[B_NOLOAD_PQ];
		pend[B_NOLOAD_APP] = status[B_NOLOAD_APP] & r.enable[B_NOLOAD_APP];
		pend[B_VOLT_TIMEOUT +: 3] = status[B_VOLT_TIMEOUT +: 3]
			& r.enable[B_VOLT_TIMEOUT +: 3];
		pend[B_CURR_TIMEOUT +: 3] = status[B_CURR_TIMEOUT +: 3]
			& r.enable[B_CURR_TIMEOUT +: 3];
		pend[B_VOLT_CROSS +: 3] = status[B_VOLT_CROSS +: 3]
			& r.enable[B_VOLT_CROSS +: 3];
		pend[B_CURR_CROSS +: 3] = status[B_CURR_CROSS +: 3]
			& r.enable[B_CURR_CROSS +: 3];
		pend[B_DIP] = status[B_DIP] & r.enable[B_DIP];
		pend[B_HIGH_CURR] = status[B_HIGH_CURR] & r.enable[B_HIGH_CURR];
		pend[B_HIGH_VOLT] = status[B_HIGH_VOLT] & r.enable[B_HIGH_VOLT];
		pend[B_PHASE_ORDER] = status[B_PHASE_ORDER]
			& r.enable[B_PHASE_ORDER];
		pend[B_PEAK_CURR] = status[B_PEAK_CURR] & r.enable[B_PEAK_CURR];
		pend[B_PEAK_VOLT] = status[B_PEAK_VOLT] & r.enable[B_PEAK_VOLT];
		pend = pend & GATE_MASK;
	end

	assign irq_n = !((|pend) || status[B_RESET_DONE]);

	// ------------------------------------------------------------
	// register update
	// ------------------------------------------------------------
	always_comb
	begin
		next_r = r;
		next_r.booted = 1'b1;
		case (r.state)
			ST_IDLE:
			begin
				if (setup)
				begin
					next_r.state = ST_ACCESS;
					next_r.rdata = pwrite ? 32'h0000_0000 : rd_mux;
					next_r.err = !hit;
				end
			end
			ST_ACCESS:
			begin
				next_r.state = ST_IDLE;
				next_r.err = 1'b0;
			end
			default:
			begin
				next_r.state = ST_IDLE;
			end
		endcase
		if (commit && pwrite && sel_enable)
			next_r.enable = pwdata & ENABLE_WR_MASK;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r.state <= ST_IDLE;
			r.rdata <= 32'h0000_0000;
			r.err <= 1'b0;
			r.enable <= ENABLE_RESET;
			r.booted <= 1'b0;
		end
		else
			r <= next_r;
	end

	assign prdata = r.rdata;
	assign pslverr = r.err && pready;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence apb_setup_s;
		psel && !penable;
	endsequence

	sequence enable_write_s;
		commit && pwrite && sel_enable;
	endsequence

	sequence status_clear_s(int b);
		commit && pwrite && sel_status && pwdata[b];
	endsequence

	sequence phase_order_event_s;
		event_pulse[B_PHASE_ORDER] && r.enable[B_PHASE_ORDER];
	endsequence

	enable_store_a: assert property (
		enable_write_s |=> (r.enable == ($past(pwdata) & ENABLE_WR_MASK)))
		else $error("enable register did not take written value");

	reserved_zero_a: assert property (
		(r.enable & ~ENABLE_WR_MASK) == 32'h0000_0000)
		else $error("reserved enable bit became set");

	access_ready_a: assert property (
		apb_setup_s |=> pready ##1 !pready)
		else $error("access phase not one cycle");

	reset_done_irq_a: assert property (
		status[B_RESET_DONE] |-> !irq_n)
		else $error("reset-done flag did not assert request");

	dip_event_irq_a: assert property (
		event_pulse[B_DIP] && r.enable[B_DIP]
		&& !(commit && pwrite && sel_enable)
		|=> !irq_n)
		else $error("enabled dip event did not assert request");

	noload_app_irq_a: assert property (
		event_pulse[B_NOLOAD_APP] && r.enable[B_NOLOAD_APP]
		&& !(commit && pwrite && sel_enable)
		|=> !irq_n)
		else $error("enabled apparent no-load event did not assert request");

	phase_order_irq_a: assert property (
		phase_order_event_s |=> !irq_n)
		else $error("enabled phase order event did not assert request");

	masked_quiet_a: assert property (
		(r.enable == 32'h0000_0000) && !status[B_RESET_DONE] |-> irq_n)
		else $error("request with all enables cleared");

	volt_phase_a: assert property (
		event_pulse[B_HIGH_VOLT] |=> ((phase_source_status[P_HIGH_VOLT +: 3]
		& $past(high_voltage_phase_flags)) == $past(high_voltage_phase_flags)))
		else $error("overvoltage phase not recorded");

	curr_phase_a: assert property (
		event_pulse[B_HIGH_CURR] |=> ((phase_source_status[P_HIGH_CURR +: 3]
		& $past(high_current_phase_flags)) == $past(high_current_phase_flags)))
		else $error("overcurrent phase not recorded");

	// a clear with no new event must empty the flag and its phase record
	curr_clear_a: assert property (
		status_clear_s(B_HIGH_CURR) ##0 !event_pulse[B_HIGH_CURR]
		|=> !status[B_HIGH_CURR] && (phase_source_status[P_HIGH_CURR +: 3] == 3'h0))
		else $error("overcurrent flag or phase record not cleared");

	// set wins: an event landing on its own clear stays visible
	set_wins_a: assert property (
		(event_pulse[B_NOLOAD_PQ] and status_clear_s(B_NOLOAD_PQ))
		|=> status[B_NOLOAD_PQ])
		else $error("event lost against its clear");

	reserved_status_a: assert property (
		(status & ~STATUS_MASK) == 32'h0000_0000)
		else $error("reserved status bit became set");

	unmapped_err_a: assert property (
		psel && !penable && !hit |=> pslverr)
		else $error("unmapped access not refused");

	irq_cause_a: assert property (
		!irq_n |-> (|(status & r.enable & GATE_MASK))
		|| status[B_RESET_DONE])
		else $error("request without an enabled cause");

	boot_flag_a: assert property (
		$rose(r.booted) |-> status[B_RESET_DONE] && !irq_n)
		else $error("reset-done flag not raised after reset");

endmodule : power_quality_irq_mask

// File: test/power_quality_irq_mask_bench.sv
`timescale 1ns/100ps
module power_quality_irq_mask_bench
	import pq_irq_pkg::*;
;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] event_pulse = '0;
	logic [2:0] hc_flags = '0;
	logic [2:0] hv_flags = '0;
	logic [2:0] dip_flags = '0;
	logic irq_n;
	int mismatches = 0;
	int tests_run = 0;
	// byte addresses are four times the register index
	localparam logic [17:0] A_EN = {ENABLE_IDX, 2'b00};
	localparam logic [17:0] A_ST = {STATUS_IDX, 2'b00};
	localparam logic [17:0] A_PH = {PHSRC_IDX, 2'b00};
	// events that an enable bit is allowed to gate
	localparam logic [31:0] GATED = 32'h018f_7ffd;

	power_quality_irq_mask dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.event_pulse(event_pulse), .high_current_phase_flags(hc_flags),
		.high_voltage_phase_flags(hv_flags), .dip_phase_flags(dip_flags),
		.irq_n(irq_n)
	);

	initial
	begin
		forever #10 pclk = ~pclk;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] y);
		tests_run++;
		if (y !== x)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, x, y);
			mismatches++;
		end
	endtask : chk

	// one apb transfer; starts one edge after the previous release
	task automatic apb(input logic wr, input logic [17:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for ready
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [17:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		chk("write error", 32'h0, {31'h0, e});
	endtask : wr

	task automatic rd(input string nm, input logic [17:0] a,
		input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(nm, x, q);
		chk("read error", 32'h0, {31'h0, e});
	endtask : rd

	task automatic irq(input logic x);
		@(negedge pclk);
		chk("irq_n", {31'h0, x}, {31'h0, irq_n});
	endtask : irq

	task automatic pulse(input logic [31:0] b, input logic [2:0] hc,
		input logic [2:0] hv, input logic [2:0] dp);
		@(posedge pclk);
		event_pulse <= b;
		hc_flags <= hc;
		hv_flags <= hv;
		dip_flags <= dp;
		@(posedge pclk);
		event_pulse <= '0;
		hc_flags <= '0;
		hv_flags <= '0;
		dip_flags <= '0;
	endtask : pulse

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	initial
	begin
		repeat (6000) @(posedge pclk);
		mismatches++;
		end_sim();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		logic [31:0] q;
		logic e;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// reset-done flag sets on the first edge after release
		@(posedge pclk);
		irq(1'b0);
		rd("enable reset", A_EN, 32'h0);
		wr(A_ST, 32'h0000_8000);
		irq(1'b1);
		// reserved places read zero and bit 15 reads back without effect
		wr(A_EN, 32'hffff_ffff);
		rd("enable mask", A_EN, 32'h018f_fffd);
		pulse(32'hfe70_8002, 3'h0, 3'h0, 3'h0);
		irq(1'b1);
		rd("reserved status", A_ST, 32'h0);
		// each gated event, first masked and then enabled
		for (int i = 0; i < 32; i++)
		begin
			if (GATED[i])
			begin
				wr(A_EN, 32'h0);
				pulse(32'h1 << i, 3'h0, 3'h0, 3'h0);
				irq(1'b1);
				rd("status bit", A_ST, 32'h1 << i);
				wr(A_EN, 32'h1 << i);
				irq(1'b0);
				wr(A_ST, 32'h1 << i);
				irq(1'b1);
				pulse(32'h1 << i, 3'h0, 3'h0, 3'h0);
				irq(1'b0);
				wr(A_ST, 32'h1 << i);
				irq(1'b1);
			end
		end
		// phase flags record which phase caused dip, high current, high volt
		wr(A_EN, 32'h0002_0000);
		pulse(32'h0007_0000, 3'b010, 3'b100, 3'b001);
		irq(1'b0);
		rd("phase source", A_PH, 32'h0000_1810);
		wr(A_PH, 32'hffff_ffff);
		rd("phase source ro", A_PH, 32'h0000_1810);
		wr(A_ST, 32'h0007_0000);
		irq(1'b1);
		rd("phase source clr", A_PH, 32'h0);
		wr(A_EN, 32'h0180_0000);
		pulse(32'h0180_0000, 3'h0, 3'h0, 3'h0);
		irq(1'b0);
		rd("peak status", A_ST, 32'h0180_0000);
		wr(A_ST, 32'h0080_0000);
		irq(1'b0);
		wr(A_ST, 32'h0100_0000);
		irq(1'b1);
		// unmapped and unaligned places are refused
		apb(1'b0, 18'h00010, 32'h0, q, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		apb(1'b1, A_EN + 18'h1, 32'h0000_0fff, q, e);
		chk("unaligned err", 32'h1, {31'h0, e});
		rd("enable kept", A_EN, 32'h0180_0000);
		// event pulse stands at the access edge of its own clear: set wins
		fork
			wr(A_ST, 32'h0000_0001);
			begin
				@(posedge pclk);
				pulse(32'h0000_0001, 3'h0, 3'h0, 3'h0);
			end
		join
		rd("set wins", A_ST, 32'h0000_0001);
		irq(1'b1);
		wr(A_ST, 32'h0000_0001);
		rd("set wins clr", A_ST, 32'h0);
		end_sim();
	end

endmodule : power_quality_irq_mask_bench
